// *** phg_pkg.sv ***
// port h gpio package: register map, field positions, reset values, mode and state codes
package phg_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] PHG_PULLUP_ASSIGN_OFS = 8'h2c;
  localparam logic [7:0] PHG_SYSTEM_SETUP_OFS = 8'h3f;
  localparam logic [7:0] PHG_PIN_ALT_ENABLE_OFS = 8'h7b;
  localparam logic [7:0] PHG_PIN_DATA_OFS = 8'h7c;
  localparam logic [7:0] PHG_PIN_DIRECTION_OFS = 8'h7d;

  // pullup_assign field positions, one enable per port
  localparam int PHG_PORT_B_PULLUP_BIT = 0;
  localparam int PHG_PORT_F_PULLUP_BIT = 1;
  localparam int PHG_PORT_G_PULLUP_BIT = 2;
  localparam int PHG_PORT_H_PULLUP_BIT = 3;

  // system_setup field position of the pullup assignment enable
  localparam int PHG_PULLUP_ASSIGN_ENABLE_BIT = 2;

  // pin_alt_enable field positions
  localparam int PHG_ALT_PROG_CS_BIT = 7;
  localparam int PHG_ALT_GEN_CS_LSB = 4;
  localparam int PHG_ALT_PWM_LSB = 0;

  // values after reset
  localparam logic [7:0] PHG_DATA_RST = 8'h00;
  localparam logic [7:0] PHG_DIRECTION_RST = 8'h00;
  localparam logic [7:0] PHG_PULLUP_ASSIGN_RST = 8'h00;
  localparam logic [7:0] PHG_SYSTEM_SETUP_RST = 8'h00;
  localparam logic [7:0] PHG_ALT_ENABLE_RST = 8'h00;
  localparam logic [7:0] PHG_READ_RST = 8'h00;

  // bits that exist on the reduced-pin and full variants
  localparam logic [7:0] PHG_REDUCED_MASK = 8'h0f;
  localparam logic [7:0] PHG_FULL_MASK = 8'hff;

  // cycles after reset release before the synchronised mode pins are trusted
  localparam logic [1:0] PHG_MODE_SETTLE_CYCLES = 2'h2;

  // operating mode pin codes
  typedef enum logic [1:0] {
    PHG_MODE_BOOT = 2'b00,
    PHG_MODE_SINGLE = 2'b01,
    PHG_MODE_TEST = 2'b10,
    PHG_MODE_EXPANDED = 2'b11
  } phg_mode_t;

  // start-up sequencer states
  typedef enum logic {
    PHG_ST_SETTLE = 1'b0,
    PHG_ST_RUN = 1'b1
  } phg_state_t;

endpackage : phg_pkg

// *** phg_sync.sv ***
// two-flop synchroniser for pin levels entering the mclk domain
`timescale 1ns/1ps
module phg_sync #(
  parameter int W = 10
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  // first stage: only the second stage reads it
  logic [W-1:0] metaStage;

  // both stages clear to zero under reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      metaStage <= '0;
      syncOut <= '0;
    end else begin
      metaStage <= asyncIn;
      syncOut <= metaStage;
    end
  end

endmodule : phg_sync

// *** phg_port_h.sv ***
// port h general-purpose i/o with alternate functions and port pullup control
//
// Overview of operation
// - single-chip/boot: pin seven resets as input
// - expanded/test: pin seven starts as program select
// - pins six to zero reset as inputs
// - expanded/test: pins six-four carry chip selects
// - pins three to zero may carry pwm
// - direction bit zero input, one output
// - reduced variant: bits seven-four absent
// - every pin has a pullup, switched on and off per port
// - pullup_assign bit enables a whole port
// - assignment honoured only while enable bit set
// - enable bit one turns pullups on
// - expanded modes ignore port f, b enables
// - system_setup write-once normal, free in special
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module phg_port_h
  import phg_pkg::*;
#(
  parameter bit REDUCED_PINS = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [1:0] modeSel,
  input wire logic [7:0] portPinIn,
  output logic [7:0] portPinOut,
  output logic [7:0] portPinOe,
  input wire logic programChipSelect,
  input wire logic generalChipSelectTwo,
  input wire logic generalChipSelectOne,
  input wire logic ioChipSelect,
  input wire logic pwmOutFour,
  input wire logic pwmOutThree,
  input wire logic pwmOutTwo,
  input wire logic pwmOutOne,
  output logic portBPullup,
  output logic portFPullup,
  output logic portGPullup,
  output logic [7:0] portHPullup
);

  // bits that physically exist on this variant
  localparam logic [7:0] IMPL_MASK = REDUCED_PINS ? PHG_REDUCED_MASK : PHG_FULL_MASK;

  // synchronised pin levels and mode straps
  logic [7:0] pinSync;
  logic [1:0] modeSync;

  // start-up sequencer and captured mode
  phg_state_t state;
  phg_state_t next_state;
  logic [1:0] settleCnt;
  logic [1:0] next_settleCnt;
  phg_mode_t mode;
  phg_mode_t next_mode;
  logic running;
  logic modeExp;
  logic modeSpecial;

  // software registers
  logic [7:0] dataReg;
  logic [7:0] next_dataReg;
  logic [7:0] dirReg;
  logic [7:0] next_dirReg;
  logic [7:0] pullupAssign;
  logic [7:0] next_pullupAssign;
  logic [7:0] setupReg;
  logic [7:0] next_setupReg;
  logic setupWritten; // once set, normal modes lock system_setup
  logic next_setupWritten;
  logic [7:0] altCtl;
  logic [7:0] next_altCtl;

  // pin and pullup next values
  logic [7:0] next_portPinOut;
  logic [7:0] next_portPinOe;
  logic [7:0] next_regRdData;
  logic next_portBPullup;
  logic next_portFPullup;
  logic next_portGPullup;
  logic next_portHPullup;

  // per-pin ownership and alternate value
  logic [7:0] altOwn;
  logic [7:0] altVal;
  logic [7:0] pinRead;
  logic setupWrOk;
  logic pullupsLive;

  // pins and mode straps come from outside, so both pass two flops
  phg_sync #(
    .W(10)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn({modeSel, portPinIn}),
    .syncOut({modeSync, pinSync})
  );

  assign running = (state == PHG_ST_RUN);
  assign modeExp = (mode == PHG_MODE_EXPANDED) || (mode == PHG_MODE_TEST);
  assign modeSpecial = (mode == PHG_MODE_BOOT) || (mode == PHG_MODE_TEST);

  // start-up: wait for the synchronised straps, then catch the mode once
  always_comb begin
    next_state = state;
    next_settleCnt = settleCnt;
    next_mode = mode;
    case (state)
      PHG_ST_SETTLE: begin
        if (settleCnt == PHG_MODE_SETTLE_CYCLES) begin
          next_state = PHG_ST_RUN;
          next_mode = phg_mode_t'(modeSync);
        end else begin
          next_settleCnt = settleCnt + 2'h1;
        end
      end
      PHG_ST_RUN: begin
        next_state = PHG_ST_RUN; // mode stays fixed until the next reset
      end
      default: begin
        next_state = PHG_ST_SETTLE;
      end
    endcase
  end

  // start-up registers: constants only under reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PHG_ST_SETTLE;
      settleCnt <= 2'h0;
      mode <= PHG_MODE_SINGLE;
    end else begin
      state <= next_state;
      settleCnt <= next_settleCnt;
      mode <= next_mode;
    end
  end

  // normal modes take one write, special modes take any number
  assign setupWrOk = modeSpecial || !setupWritten;

  // register writes and the mode-dependent start of pin seven
  always_comb begin
    next_dataReg = dataReg;
    next_dirReg = dirReg;
    next_pullupAssign = pullupAssign;
    next_setupReg = setupReg;
    next_setupWritten = setupWritten;
    next_altCtl = altCtl;
    if (state == PHG_ST_SETTLE && next_state == PHG_ST_RUN) begin
      // program select owns pin seven from the start in expanded and test modes
      if (next_mode == PHG_MODE_EXPANDED || next_mode == PHG_MODE_TEST) begin
        next_altCtl[PHG_ALT_PROG_CS_BIT] = IMPL_MASK[PHG_ALT_PROG_CS_BIT];
      end
    end
    if (regWrStb) begin
      case (regAddr)
        PHG_PIN_DATA_OFS: begin
          next_dataReg = regWrData & IMPL_MASK;
        end
        PHG_PIN_DIRECTION_OFS: begin
          next_dirReg = regWrData & IMPL_MASK;
        end
        PHG_PULLUP_ASSIGN_OFS: begin
          next_pullupAssign = regWrData;
        end
        PHG_SYSTEM_SETUP_OFS: begin
          if (setupWrOk) begin
            next_setupReg = regWrData;
            next_setupWritten = 1'b1;
          end
        end
        PHG_PIN_ALT_ENABLE_OFS: begin
          next_altCtl = regWrData & IMPL_MASK; // software may hand pin seven back to gpio
        end
        default: begin
          next_dataReg = dataReg; // unmapped writes are dropped
        end
      endcase
    end
  end

  // software registers: pins six to zero reset to inputs in every mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dataReg <= PHG_DATA_RST;
      dirReg <= PHG_DIRECTION_RST;
      pullupAssign <= PHG_PULLUP_ASSIGN_RST;
      setupReg <= PHG_SYSTEM_SETUP_RST;
      setupWritten <= 1'b0;
      altCtl <= PHG_ALT_ENABLE_RST;
    end else begin
      dataReg <= next_dataReg;
      dirReg <= next_dirReg;
      pullupAssign <= next_pullupAssign;
      setupReg <= next_setupReg;
      setupWritten <= next_setupWritten;
      altCtl <= next_altCtl;
    end
  end

  // chip selects need an external bus, pwm works in any mode
  assign altOwn[7] = altCtl[PHG_ALT_PROG_CS_BIT] && modeExp && IMPL_MASK[7];
  assign altOwn[6:4] = altCtl[PHG_ALT_GEN_CS_LSB +: 3] & {3{modeExp}} & IMPL_MASK[6:4];
  assign altOwn[3:0] = altCtl[PHG_ALT_PWM_LSB +: 4];
  assign altVal = {programChipSelect, generalChipSelectTwo, generalChipSelectOne, ioChipSelect,
                   pwmOutFour, pwmOutThree, pwmOutTwo, pwmOutOne};

  // per-pin driver: alternate first, then direction bit with data bit
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      // nothing drives before the mode is known, absent pins never drive
      assign next_portPinOe[i] = running && IMPL_MASK[i] && (altOwn[i] || dirReg[i]);
      assign next_portPinOut[i] = altOwn[i] ? altVal[i] : (dataReg[i] && IMPL_MASK[i]);
      // outputs read back the latch, inputs read the pin
      assign pinRead[i] = IMPL_MASK[i] && (dirReg[i] ? dataReg[i] : pinSync[i]);
    end
  endgenerate

  // pullups: assignment register counts only behind its enable bit
  assign pullupsLive = setupReg[PHG_PULLUP_ASSIGN_ENABLE_BIT];
  always_comb begin
    next_portHPullup = pullupsLive && pullupAssign[PHG_PORT_H_PULLUP_BIT];
    next_portGPullup = pullupsLive && pullupAssign[PHG_PORT_G_PULLUP_BIT];
    // ports b and f carry the address bus in expanded modes
    next_portFPullup = pullupsLive && pullupAssign[PHG_PORT_F_PULLUP_BIT] && !modeExp;
    next_portBPullup = pullupsLive && pullupAssign[PHG_PORT_B_PULLUP_BIT] && !modeExp;
  end

  // read mux: data stand one cycle after the strobe and only there
  always_comb begin
    next_regRdData = PHG_READ_RST;
    if (regRdStb) begin
      case (regAddr)
        PHG_PIN_DATA_OFS: next_regRdData = pinRead;
        PHG_PIN_DIRECTION_OFS: next_regRdData = dirReg;
        PHG_PULLUP_ASSIGN_OFS: next_regRdData = pullupAssign;
        PHG_SYSTEM_SETUP_OFS: next_regRdData = setupReg;
        PHG_PIN_ALT_ENABLE_OFS: next_regRdData = altCtl;
        default: next_regRdData = PHG_READ_RST; // unmapped reads give zero
      endcase
    end
  end

  // every output comes from a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      portPinOut <= 8'h00;
      portPinOe <= 8'h00;
      regRdData <= PHG_READ_RST;
      portBPullup <= 1'b0;
      portFPullup <= 1'b0;
      portGPullup <= 1'b0;
      portHPullup <= 8'h00;
    end else begin
      portPinOut <= next_portPinOut;
      portPinOe <= next_portPinOe;
      regRdData <= next_regRdData;
      portBPullup <= next_portBPullup;
      portFPullup <= next_portFPullup;
      portGPullup <= next_portGPullup;
      portHPullup <= {8{next_portHPullup}};
    end
  end

  // checks on the pin drivers, pullups and register port

  property p_pin7_single;
    @(posedge mclk) disable iff (!rst_b)
      $rose(running) && !modeExp |=> (!portPinOe[7]) [*3];
  endproperty
  a_pin7_single: assert property (p_pin7_single) else $error("pin seven driven after reset in single-chip");
  property p_pin7_prog;
    @(posedge mclk) disable iff (!rst_b)
      $rose(running) && modeExp && IMPL_MASK[7] |=> portPinOe[7] && portPinOut[7] == $past(programChipSelect);
  endproperty
  a_pin7_prog: assert property (p_pin7_prog) else $error("program select not on pin seven after reset");
  property p_low_inputs;
    @(posedge mclk) disable iff (!rst_b)
      $rose(running) |=> portPinOe[6:0] == 7'h00;
  endproperty
  a_low_inputs: assert property (p_low_inputs) else $error("low pins not inputs after reset");
  property p_gen_cs;
    @(posedge mclk) disable iff (!rst_b)
      running && modeExp && altCtl[PHG_ALT_GEN_CS_LSB] && IMPL_MASK[4] |=> portPinOe[4] && portPinOut[4] == $past(ioChipSelect);
  endproperty
  a_gen_cs: assert property (p_gen_cs) else $error("chip select missing on pin four");
  property p_pwm;
    @(posedge mclk) disable iff (!rst_b)
      running && altCtl[PHG_ALT_PWM_LSB] |=> portPinOe[0] && portPinOut[0] == $past(pwmOutOne);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm missing on pin zero");
  property p_dir_input;
    @(posedge mclk) disable iff (!rst_b)
      !dirReg[2] && !altCtl[PHG_ALT_PWM_LSB + 2] |=> !portPinOe[2];
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin two is driven");
  property p_reduced;
    @(posedge mclk) disable iff (!rst_b)
      REDUCED_PINS |-> portPinOe[7:4] == 4'h0 && dirReg[7:4] == 4'h0 && dataReg[7:4] == 4'h0;
  endproperty
  a_reduced: assert property (p_reduced) else $error("absent high bits active");
  property p_pullup_gate;
    @(posedge mclk) disable iff (!rst_b)
      !setupReg[PHG_PULLUP_ASSIGN_ENABLE_BIT] |=> portHPullup == 8'h00 && !portGPullup;
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("pullup on while assignment disabled");
  property p_pullup_on;
    @(posedge mclk) disable iff (!rst_b)
      setupReg[PHG_PULLUP_ASSIGN_ENABLE_BIT] && pullupAssign[PHG_PORT_H_PULLUP_BIT] |=> portHPullup == 8'hff;
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("port h pullups not on");
  property p_exp_ignore;
    @(posedge mclk) disable iff (!rst_b)
      modeExp |=> !portBPullup && !portFPullup;
  endproperty
  a_exp_ignore: assert property (p_exp_ignore) else $error("port b or f pullup on in expanded mode");
  property p_write_once;
    @(posedge mclk) disable iff (!rst_b)
      setupWritten && !modeSpecial && regWrStb && regAddr == PHG_SYSTEM_SETUP_OFS |=> $stable(setupReg);
  endproperty
  a_write_once: assert property (p_write_once) else $error("system_setup rewritten in normal mode");
  property p_gpio_drive;
    @(posedge mclk) disable iff (!rst_b)
      running && dirReg[3] && !altCtl[PHG_ALT_PWM_LSB + 3] |=> portPinOe[3] && portPinOut[3] == $past(dataReg[3]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("output pin three not driven with data");

endmodule : phg_port_h

// *** phg_pin_board.sv ***
// board model: resolves each port h pin from design drive, board drive and pullup
`timescale 1ns/1ps
module phg_pin_board (
  input wire logic mclk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupOn,
  input wire logic [7:0] boardVal,
  input wire logic [7:0] boardOe,
  output logic [7:0] pinLevel
);
  // undriven pin with no pullup: changes every cycle so no stale value hides a fault
  logic [7:0] floatVal = 8'h00;
  always @(posedge mclk) begin
    floatVal <= ~floatVal;
  end
  // design drive wins, then board, then pullup, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (boardOe[i]) pinLevel[i] = boardVal[i];
      else if (pullupOn[i]) pinLevel[i] = 1'b1;
      else pinLevel[i] = floatVal[i];
    end
  end
endmodule : phg_pin_board

// *** phg_port_h_tb_top.sv ***
// self-checking testbench for the port h gpio block
`timescale 1ns/1ps
module phg_port_h_tb_top
  import phg_pkg::*;
;
  logic mclk = 1'b0; // 40 MHz system clock
  logic rst_b = 1'b0; // reset, active low
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [1:0] modeSel = 2'b01;
  logic [7:0] boardVal = 8'h00; // board drive value
  logic [7:0] boardOe = 8'h00; // board drive enable
  logic [3:0] csIn = 4'ha; // chip select inputs, pins 7..4
  logic [3:0] pwmIn = 4'ha; // pwm inputs, pins 3..0
  logic [7:0] regRdData, redRdData, portPinOut, portPinOe, redPinOe, portHPullup, pinLevel;
  logic portBPullup, portFPullup, portGPullup;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  always #12.5 mclk = ~mclk;

  // full variant under test
  phg_port_h #(.REDUCED_PINS(1'b0)) u_phg_port_h (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .modeSel(modeSel), .portPinIn(pinLevel),
    .portPinOut(portPinOut), .portPinOe(portPinOe), .programChipSelect(csIn[3]),
    .generalChipSelectTwo(csIn[2]), .generalChipSelectOne(csIn[1]), .ioChipSelect(csIn[0]),
    .pwmOutFour(pwmIn[3]), .pwmOutThree(pwmIn[2]), .pwmOutTwo(pwmIn[1]), .pwmOutOne(pwmIn[0]),
    .portBPullup(portBPullup), .portFPullup(portFPullup), .portGPullup(portGPullup),
    .portHPullup(portHPullup));

  // reduced-pin variant on the same register traffic
  phg_port_h #(.REDUCED_PINS(1'b1)) u_phg_port_h_red (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(redRdData), .modeSel(modeSel), .portPinIn(pinLevel),
    .portPinOut(), .portPinOe(redPinOe), .programChipSelect(csIn[3]),
    .generalChipSelectTwo(csIn[2]), .generalChipSelectOne(csIn[1]), .ioChipSelect(csIn[0]),
    .pwmOutFour(pwmIn[3]), .pwmOutThree(pwmIn[2]), .pwmOutTwo(pwmIn[1]), .pwmOutOne(pwmIn[0]),
    .portBPullup(), .portFPullup(), .portGPullup(), .portHPullup());

  // far side: pins and board devices
  phg_pin_board u_phg_pin_board (
    .mclk(mclk), .pinOut(portPinOut), .pinOe(portPinOe), .pullupOn(portHPullup),
    .boardVal(boardVal), .boardOe(boardOe), .pinLevel(pinLevel));

  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data sampled in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  // let register effects reach pins and pullups
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  // mode is caught after release, so first access waits past capture
  task automatic do_reset(input logic [1:0] m);
    @(posedge mclk);
    rst_b <= 1'b0;
    modeSel <= m;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : do_reset

  // reset state per mode, then pwm and chip select ownership
  task automatic t_modes(input logic [1:0] m);
    logic [7:0] d;
    do_reset(m);
    boardOe <= 8'h00;
    #1;
    chk(portPinOe, m[1] ? 8'h80 : 8'h00);
    if (m[1]) chk(portPinOut & 8'h80, 8'h80);
    chk(redPinOe, 8'h00);
    chk(portHPullup, 8'h00);
    rd(PHG_PIN_DIRECTION_OFS, d);
    chk(d, PHG_DIRECTION_RST);
    rd(PHG_PIN_ALT_ENABLE_OFS, d);
    chk(d, m[1] ? 8'h80 : 8'h00);
    wr(PHG_PIN_ALT_ENABLE_OFS, 8'hff);
    settle();
    chk(portPinOe, m[1] ? 8'hff : 8'h0f);
    chk(portPinOut & 8'h0f, 8'h0a);
    if (m[1]) chk(portPinOut & 8'hf0, 8'ha0);
    chk(redPinOe, 8'h0f);
    // flip every alternate source so a stuck pattern cannot pass
    @(posedge mclk);
    csIn <= 4'h5;
    pwmIn <= 4'h5;
    settle();
    chk(portPinOut, m[1] ? 8'h55 : 8'h05);
    @(posedge mclk);
    csIn <= 4'ha;
    pwmIn <= 4'ha;
    $display("test modes %0d done", m);
  endtask : t_modes

  // program select given back to general i/o
  task automatic t_regain();
    do_reset(2'b11);
    wr(PHG_PIN_ALT_ENABLE_OFS, 8'h00);
    wr(PHG_PIN_DIRECTION_OFS, 8'h80);
    wr(PHG_PIN_DATA_OFS, 8'h00);
    settle();
    chk(portPinOe, 8'h80);
    chk(portPinOut & 8'h80, 8'h00);
    $display("test regain done");
  endtask : t_regain

  // mixed directions, readback, reduced variant, unmapped address
  task automatic t_dir_data();
    logic [7:0] d;
    do_reset(2'b01);
    boardOe <= 8'ha5;
    boardVal <= 8'h3c;
    wr(PHG_PIN_DIRECTION_OFS, 8'h5a);
    wr(PHG_PIN_DATA_OFS, 8'hc3);
    settle();
    chk(portPinOe, 8'h5a);
    chk(portPinOut & 8'h5a, 8'h42);
    chk(redPinOe, 8'h0a);
    repeat (3) @(posedge mclk);
    rd(PHG_PIN_DATA_OFS, d);
    chk(d, 8'h66);
    chk(redRdData, 8'h06);
    rd(PHG_PIN_DIRECTION_OFS, d);
    chk(d, 8'h5a);
    chk(redRdData, 8'h0a);
    wr(8'h10, 8'h55);
    rd(8'h10, d);
    chk(d, 8'h00);
    $display("test dir data done");
  endtask : t_dir_data

  // pullup gating, write-once setup, expanded port b/f ignore
  task automatic t_pullup();
    logic [7:0] d;
    do_reset(2'b01);
    boardOe <= 8'h00;
    wr(PHG_PULLUP_ASSIGN_OFS, 8'h0f);
    settle();
    chk({5'h0, portBPullup, portFPullup, portGPullup}, 8'h00);
    chk(portHPullup, 8'h00);
    rd(PHG_PULLUP_ASSIGN_OFS, d);
    chk(d, 8'h0f);
    wr(PHG_SYSTEM_SETUP_OFS, 8'h04);
    settle();
    chk({5'h0, portBPullup, portFPullup, portGPullup}, 8'h07);
    chk(portHPullup, 8'hff);
    repeat (3) @(posedge mclk);
    rd(PHG_PIN_DATA_OFS, d);
    chk(d, 8'hff);
    wr(PHG_SYSTEM_SETUP_OFS, 8'h00);
    rd(PHG_SYSTEM_SETUP_OFS, d);
    chk(d, 8'h04);
    do_reset(2'b11);
    wr(PHG_SYSTEM_SETUP_OFS, 8'h04);
    wr(PHG_PULLUP_ASSIGN_OFS, 8'h0f);
    settle();
    chk({5'h0, portBPullup, portFPullup, portGPullup}, 8'h01);
    do_reset(2'b10);
    wr(PHG_SYSTEM_SETUP_OFS, 8'h04);
    wr(PHG_SYSTEM_SETUP_OFS, 8'h00);
    rd(PHG_SYSTEM_SETUP_OFS, d);
    chk(d, 8'h00);
    $display("test pullup done");
  endtask : t_pullup

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // main sequence: hold reset 3 cycles, then every scenario
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      t_modes(m[1:0]);
    end
    t_regain();
    t_dir_data();
    t_pullup();
    report_and_stop();
  end
endmodule : phg_port_h_tb_top
